// File: design/multiplier_control_reg_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MUL_OSC_DEFS_SVH
`define MUL_OSC_DEFS_SVH
`define OFS_MUL_CTRL      12'h000
`define OFS_XOSC_CTRL     12'h004
`define OFS_IRQ_STATUS    12'h008
`define OFS_IRQ_MASK      12'h00C
`define MUL_CTRL_RESET    8'h00
`define XOSC_CTRL_RESET   8'h00
`define IRQ_MASK_RESET    2'b00
`define MUL_EN_BIT        7
`define MUL_INIT_BIT      6
`define MUL_RDY_BIT       5
`define MUL_DIV_LSB       2
`define MUL_SEL_LSB       0
`define XOSC_MODE_LSB     4
`define XOSC_FREQ_LSB     0
`define IRQ_RDY_SET_BIT   0
`define IRQ_RDY_LOST_BIT  1
`define CLK_PERIOD_NS     25
`define MUL_SETTLE_NS     5000
`define MUL_LOCK_CYCLES   16
`define MUL_PULSE_GAP     1
`endif

// File: design/multiplier_control_reg_pkg.sv
// types shared by the clock multiplier and oscillator control block
package mul_osc_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_SETTLE, ST_WAIT_INIT, ST_LOCK,
                            ST_READY} mul_state_t;
  typedef enum logic [1:0] {SRC_EXT = 2'b00, SRC_INT_HALF = 2'b01,
                            SRC_EXT_HALF = 2'b10} mul_src_t;
  typedef enum logic [2:0] {XOSC_OFF = 3'b000, XOSC_CMOS = 3'b010,
                            XOSC_RC = 3'b100, XOSC_CAP = 3'b101,
                            XOSC_CRYSTAL = 3'b110} xosc_mode_t;
endpackage

// File: design/clock_multiplier_osc_ctrl.sv
// clock multiplier and external oscillator drive control, apb slave
`timescale 1ns/1ps
`include "multiplier_control_reg_defs.svh"
module clock_multiplier_osc_ctrl #(
  parameter int SETTLE_CYC = (`MUL_SETTLE_NS / `CLK_PERIOD_NS) + 1,
  parameter int LOCK_CYC   = `MUL_LOCK_CYCLES,
  parameter int PULSE_GAP  = `MUL_PULSE_GAP
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator pins and internal oscillator, asynchronous
  input  wire logic        crystal_input_pin,
  input  wire logic        crystal_output_pin,
  input  wire logic        int_osc_clk,
  // pin claims and oscillator settings
  output logic             claim_crystal_input_pin,
  output logic             claim_crystal_output_pin,
  output logic      [2:0]  external_osc_freq_control,
  // multiplied clock as one-cycle pulses, interrupt
  output logic             mul_clk_pulse,
  output logic             irq
);
  import mul_osc_pkg::*;
  localparam logic [7:0] CTRL_WMASK = 8'hDF;
  // group size n for the scaling factor, two pulses kept out of each group, all when n is one
  function automatic logic [2:0] scale_n(input logic [2:0] code);
    case (code)
      3'h1:    scale_n = 3'h3;
      3'h2:    scale_n = 3'h4;
      3'h3:    scale_n = 3'h5;
      3'h4:    scale_n = 3'h6;
      3'h5:    scale_n = 3'h7;
      default: scale_n = 3'h1;
    endcase
  endfunction
  logic [2:0] xin_s_r, xin_s_nxt;
  logic [2:0] xout_s_r, xout_s_nxt;
  logic [2:0] int_s_r, int_s_nxt;
  always_comb
  begin
    xin_s_nxt  = {xin_s_r[1:0], crystal_input_pin};
    xout_s_nxt = {xout_s_r[1:0], crystal_output_pin};
    int_s_nxt  = {int_s_r[1:0], int_osc_clk};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xin_s_r  <= 3'h0;
      xout_s_r <= 3'h0;
      int_s_r  <= 3'h0;
    end
    else
    begin
      xin_s_r  <= xin_s_nxt;
      xout_s_r <= xout_s_nxt;
      int_s_r  <= int_s_nxt;
    end
  end
  logic [7:0]  mul_ctrl_r, mul_ctrl_nxt;
  logic [7:0]  xosc_ctrl_r, xosc_ctrl_nxt;
  logic [1:0]  irq_stat_r, irq_stat_nxt;
  logic [1:0]  irq_mask_r, irq_mask_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        irq_r, irq_nxt;
  logic        ready_r;
  logic        ready_d_r;
  logic        acc_done;
  logic        wr_ctrl;
  mul_state_t  state_r, state_nxt;
  assign acc_done = psel & penable & pready_r;
  assign wr_ctrl  = acc_done & pwrite & (paddr == `OFS_MUL_CTRL);
  always_comb
  begin
    mul_ctrl_nxt  = mul_ctrl_r;
    xosc_ctrl_nxt = xosc_ctrl_r;
    irq_mask_nxt  = irq_mask_r;
    irq_stat_nxt  = irq_stat_r;
    prdata_nxt    = prdata_r;
    pslverr_nxt   = 1'b0;
    // zero wait state: answer stands during the access cycle
    pready_nxt    = psel & ~penable;
    if (psel & ~penable)
    begin
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `OFS_MUL_CTRL:   prdata_nxt[7:0] = mul_ctrl_r;
        `OFS_XOSC_CTRL:  prdata_nxt[7:0] = xosc_ctrl_r;
        `OFS_IRQ_STATUS: prdata_nxt[1:0] = irq_stat_r;
        `OFS_IRQ_MASK:   prdata_nxt[1:0] = irq_mask_r;
        default:         pslverr_nxt     = 1'b1;
      endcase
    end
    if (acc_done & pwrite)
    begin
      case (paddr)
        // a zero write clears enable, init and fields at once
        `OFS_MUL_CTRL:  mul_ctrl_nxt  = pwdata[7:0] & CTRL_WMASK;
        `OFS_XOSC_CTRL: xosc_ctrl_nxt = pwdata[7:0];
        `OFS_IRQ_MASK:  irq_mask_nxt  = pwdata[1:0];
        default:        ;
      endcase
    end
    if (acc_done & ~pwrite & (paddr == `OFS_IRQ_STATUS))
      irq_stat_nxt = 2'b00;
    // new events win over the read clear
    if (ready_r & ~ready_d_r)
      irq_stat_nxt[`IRQ_RDY_SET_BIT] = 1'b1;
    if (~ready_r & ready_d_r)
      irq_stat_nxt[`IRQ_RDY_LOST_BIT] = 1'b1;
    // ready is a live status bit, not software storage
    mul_ctrl_nxt[`MUL_RDY_BIT] = (state_nxt == ST_READY);
    irq_nxt = |(irq_stat_nxt & irq_mask_r);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mul_ctrl_r  <= `MUL_CTRL_RESET;
      xosc_ctrl_r <= `XOSC_CTRL_RESET;
      irq_mask_r  <= `IRQ_MASK_RESET;
      irq_stat_r  <= 2'b00;
      prdata_r    <= 32'h0000_0000;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      irq_r       <= 1'b0;
    end
    else
    begin
      mul_ctrl_r  <= mul_ctrl_nxt;
      xosc_ctrl_r <= xosc_ctrl_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_stat_r  <= irq_stat_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      irq_r       <= irq_nxt;
    end
  end
  logic [15:0] wait_cnt_r, wait_cnt_nxt;
  logic        mul_en;
  logic        mul_init;
  assign mul_en   = mul_ctrl_r[`MUL_EN_BIT];
  assign mul_init = mul_ctrl_r[`MUL_INIT_BIT];
  always_comb
  begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    case (state_r)
      ST_OFF:
        if (mul_en)
        begin
          state_nxt    = ST_SETTLE;
          wait_cnt_nxt = 16'(SETTLE_CYC - 1);
        end
      // an early init is held until the settle time has run out
      ST_SETTLE:
        if (wait_cnt_r == 16'h0000)
          state_nxt = ST_WAIT_INIT;
        else
          wait_cnt_nxt = wait_cnt_r - 16'h0001;
      ST_WAIT_INIT:
        if (mul_init)
        begin
          state_nxt    = ST_LOCK;
          wait_cnt_nxt = 16'(LOCK_CYC - 1);
        end
      ST_LOCK:
        if (wait_cnt_r == 16'h0000)
          state_nxt = ST_READY;
        else
          wait_cnt_nxt = wait_cnt_r - 16'h0001;
      ST_READY:
        state_nxt = ST_READY;
      default:
        state_nxt = ST_OFF;
    endcase
    // an all-zero control write or a dropped enable restarts
    if (!mul_en || (wr_ctrl && pwdata[7:0] == 8'h00))
      state_nxt = ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= ST_OFF;
      wait_cnt_r <= 16'h0000;
      ready_r    <= 1'b0;
      ready_d_r  <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      ready_r    <= (state_nxt == ST_READY);
      ready_d_r  <= ready_r;
    end
  end
  xosc_mode_t xosc_mode;
  logic       ext_edge;
  logic       int_edge;
  logic       src_edge;
  logic       half_r, half_nxt;
  assign xosc_mode = xosc_mode_t'(xosc_ctrl_r[`XOSC_MODE_LSB +: 3]);
  // crystal mode senses the input pin, the other enabled modes the output pin, off senses none
  assign ext_edge = (xosc_mode == XOSC_CRYSTAL) ? (xin_s_r[1] & ~xin_s_r[2])
                  : (xosc_mode != XOSC_OFF) ? (xout_s_r[1] & ~xout_s_r[2])
                  : 1'b0;
  assign int_edge = int_s_r[1] & ~int_s_r[2];

  // halving keeps every second edge of the chosen oscillator
  always_comb
  begin
    half_nxt = half_r;
    src_edge = 1'b0;
    case (mul_src_t'(mul_ctrl_r[`MUL_SEL_LSB +: 2]))
      SRC_EXT:      src_edge = ext_edge;
      SRC_INT_HALF:
        if (int_edge)
        begin
          half_nxt = ~half_r;
          src_edge = half_r;
        end
      SRC_EXT_HALF:
        if (ext_edge)
        begin
          half_nxt = ~half_r;
          src_edge = half_r;
        end
      default:      src_edge = 1'b0;
    endcase
    if (!mul_en)
      half_nxt = 1'b0;
  end
  logic [2:0]  burst_r, burst_nxt;
  logic [7:0]  gap_r, gap_nxt;
  logic [2:0]  keep_r, keep_nxt;
  logic        pulse_nxt;
  logic        raw_pulse;
  logic [2:0]  div_n;
  assign div_n = scale_n(mul_ctrl_r[`MUL_DIV_LSB +: 3]);
  always_comb
  begin
    burst_nxt = burst_r;
    gap_nxt   = gap_r;
    keep_nxt  = keep_r;
    raw_pulse = 1'b0;
    pulse_nxt = 1'b0;
    // four pulses per input edge, then idle till the next edge
    if (burst_r != 3'h0)
    begin
      if (gap_r == 8'h00)
      begin
        raw_pulse = 1'b1;
        burst_nxt = burst_r - 3'h1;
        gap_nxt   = 8'(PULSE_GAP);
      end
      else
        gap_nxt = gap_r - 8'h01;
    end
    // a fast input restarts the burst, never two pulses back to back
    if (src_edge && ready_r)
    begin
      burst_nxt = 3'h4;
      gap_nxt   = raw_pulse ? 8'(PULSE_GAP) : 8'h00;
    end
    // pass two of every n pulses, or all when n is one
    if (raw_pulse)
    begin
      pulse_nxt = (div_n == 3'h1) || (keep_r < 3'h2);
      keep_nxt  = (keep_r + 3'h1 >= div_n) ? 3'h0 : keep_r + 3'h1;
    end
    if (!ready_r)
    begin
      burst_nxt = 3'h0;
      keep_nxt  = 3'h0;
      pulse_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      half_r                    <= 1'b0;
      burst_r                   <= 3'h0;
      gap_r                     <= 8'h00;
      keep_r                    <= 3'h0;
      mul_clk_pulse             <= 1'b0;
      claim_crystal_input_pin   <= 1'b0;
      claim_crystal_output_pin  <= 1'b0;
      external_osc_freq_control <= 3'h0;
    end
    else
    begin
      half_r                    <= half_nxt;
      burst_r                   <= burst_nxt;
      gap_r                     <= gap_nxt;
      keep_r                    <= keep_nxt;
      mul_clk_pulse             <= pulse_nxt;
      claim_crystal_input_pin   <= (xosc_mode == XOSC_CRYSTAL);
      claim_crystal_output_pin  <= (xosc_mode != XOSC_OFF);
      external_osc_freq_control <= xosc_ctrl_r[`XOSC_FREQ_LSB +: 3];
    end
  end
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;
endmodule

// File: testbench/multiplier_control_reg_props.sv
// concurrent checks on the ports of the clock multiplier block
`timescale 1ns/1ps
`include "multiplier_control_reg_defs.svh"
module mul_osc_props (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // outputs
  input wire logic        claim_crystal_input_pin,
  input wire logic        claim_crystal_output_pin,
  input wire logic [2:0]  external_osc_freq_control,
  input wire logic        mul_clk_pulse,
  input wire logic        irq
);
  import mul_osc_pkg::*;
  logic       su;
  logic       wr;
  logic       mapped;
  logic [2:0] wfreq;
  logic [2:0] wmode;
  assign su     = psel && !penable;
  assign wr     = psel && penable && pready && pwrite;
  assign mapped = paddr inside {`OFS_MUL_CTRL, `OFS_XOSC_CTRL,
                                `OFS_IRQ_STATUS, `OFS_IRQ_MASK};
  assign wfreq  = pwdata[`XOSC_FREQ_LSB +: 3];
  assign wmode  = pwdata[`XOSC_MODE_LSB +: 3];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT: assert property (su |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (su && !mapped |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (su && mapped |=> !pslverr)
    else $error("mapped access refused");
  AST_FREQ_COPY: assert property (
    wr && paddr == `OFS_XOSC_CTRL |-> ##2
    external_osc_freq_control == $past(wfreq, 2)) else $error("freq copy");
  AST_CRYSTAL_PINS: assert property (
    wr && paddr == `OFS_XOSC_CTRL && wmode == XOSC_CRYSTAL |-> ##2
    claim_crystal_input_pin && claim_crystal_output_pin)
    else $error("crystal pins not claimed");
  AST_OTHER_PINS: assert property (
    wr && paddr == `OFS_XOSC_CTRL &&
    wmode inside {XOSC_CMOS, XOSC_RC, XOSC_CAP} |-> ##2
    !claim_crystal_input_pin && claim_crystal_output_pin)
    else $error("single pin claim wrong");
  AST_PIN_PAIR: assert property (claim_crystal_input_pin |->
    claim_crystal_output_pin) else $error("input claimed alone");
  AST_PULSE_GAP: assert property (
    mul_clk_pulse |=> !mul_clk_pulse) else $error("pulses adjacent");
  AST_STOP_PULSES: assert property (
    wr && paddr == `OFS_MUL_CTRL && !pwdata[`MUL_EN_BIT] |->
    ##3 !mul_clk_pulse [*8]) else $error("pulses after disable");
  AST_MASK_OFF: assert property (wr && paddr == `OFS_IRQ_MASK &&
    pwdata[1:0] == 2'b00 |-> ##3 !irq) else $error("masked irq high");
endmodule
bind clock_multiplier_osc_ctrl mul_osc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .claim_crystal_input_pin(claim_crystal_input_pin),
  .claim_crystal_output_pin(claim_crystal_output_pin),
  .external_osc_freq_control(external_osc_freq_control),
  .mul_clk_pulse(mul_clk_pulse), .irq(irq));

// File: testbench/osc_source_model.sv
// behavioural external clock source and internal oscillator
`timescale 1ns/1ps
module osc_source_model #(
  parameter int HALF_NS = 200
) (
  // oscillator pins
  output logic crystal_input_pin,
  output logic crystal_output_pin,
  output logic int_osc_clk
);
  // pins stand still between bursts so edge counts are exact
  initial
  begin
    crystal_output_pin = 1'b0;
    crystal_input_pin  = 1'b1;
    int_osc_clk        = 1'b0;
  end
  // stable digital levels, terminals in opposition
  task automatic run(input int n);
    // off the pclk edge so the first capture flop never races
    #7;
    repeat (n)
    begin
      #HALF_NS;
      {crystal_output_pin, int_osc_clk, crystal_input_pin} = 3'b110;
      #HALF_NS;
      {crystal_output_pin, int_osc_clk, crystal_input_pin} = 3'b001;
    end
  endtask
endmodule

// File: testbench/tb_clock_multiplier_osc_ctrl.sv
// self-checking bench for the clock multiplier block
`timescale 1ns/1ps
`include "multiplier_control_reg_defs.svh"
module tb_clock_multiplier_osc_ctrl;
  import mul_osc_pkg::*;
  localparam int SETTLE = 4;
  localparam int K      = 210;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        x_in, x_out, iosc, cl_in, cl_out, pulse, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, f;
  logic [2:0]  freq;
  logic [33:0] expq[$];
  logic [33:0] e;
  int          failures = 0, comparisons = 0, pulses = 0, seed = 86;
  int          n, p0;
  xosc_mode_t  modes[5] = '{XOSC_CRYSTAL, XOSC_OFF, XOSC_RC, XOSC_CAP,
                            XOSC_CMOS};
  // {source, scale}
  logic [4:0]  cfgs[8] = '{5'h00, 5'h08, 5'h10, 5'h01, 5'h02, 5'h03,
                           5'h04, 5'h05};
  clock_multiplier_osc_ctrl #(.SETTLE_CYC(SETTLE), .LOCK_CYC(2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystal_input_pin(x_in),
    .crystal_output_pin(x_out), .int_osc_clk(iosc),
    .claim_crystal_input_pin(cl_in), .claim_crystal_output_pin(cl_out),
    .external_osc_freq_control(freq), .mul_clk_pulse(pulse), .irq(irq));
  osc_source_model u_src (.crystal_input_pin(x_in),
    .crystal_output_pin(x_out), .int_osc_clk(iosc));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dt, input logic c, input logic [32:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    if (!w) expq.push_back({c, x});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt, 1'b0, 33'h0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, 1'b1, x);
  endtask
  task automatic bring_up(input logic [4:0] c);
    logic [31:0] cfg;
    int i;
    cfg = {27'h0, c[2:0], c[4:3]};
    wr(`OFS_MUL_CTRL, 32'h0000_0000);
    wr(`OFS_MUL_CTRL, cfg);
    wr(`OFS_MUL_CTRL, cfg | 32'h0000_0080);
    repeat (2 * SETTLE) @(posedge pclk);
    wr(`OFS_MUL_CTRL, cfg | 32'h0000_00C0);
    i = 0;
    do
    begin
      apb(1'b0, `OFS_MUL_CTRL, 32'h0, 1'b0, 33'h0);
      i++;
    end
    while (rd[5] !== 1'b1 && i < 40);
    check({1'b0, rd}, {1'b0, cfg | 32'h0000_00E0});
  endtask
  // results are matched to notes in issue order
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
    begin
      e = expq.pop_front();
      if (e[33])
        check({pslverr, prdata}, e[32:0]);
    end
  always @(posedge pclk)
    if (pulse === 1'b1)
      pulses++;
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`OFS_MUL_CTRL, 33'h0);
    rdc(`OFS_XOSC_CTRL, 33'h0);
    rdc(`OFS_IRQ_STATUS, 33'h0);
    rdc(`OFS_IRQ_MASK, 33'h0);
    wr(12'h010, 32'h0000_00FF);
    rdc(12'h010, 33'h1_0000_0000);
    wr(`OFS_MUL_CTRL, 32'h0000_003F);
    rdc(`OFS_MUL_CTRL, 33'h0_0000_001F);
    foreach (modes[i])
    begin
      f = $random(seed);
      d = {25'h0, modes[i], 1'b0, f[2:0]};
      wr(`OFS_XOSC_CTRL, d);
      rdc(`OFS_XOSC_CTRL, {1'b0, d});
      check({28'h0, cl_in, cl_out, freq}, {28'h0, modes[i] == XOSC_CRYSTAL,
        modes[i] != XOSC_OFF, f[2:0]});
    end
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    bring_up(5'h00);
    check({32'h0, irq}, 33'h0);
    rdc(`OFS_IRQ_STATUS, 33'h1);
    rdc(`OFS_IRQ_STATUS, 33'h0);
    wr(`OFS_IRQ_MASK, 32'h0000_0003);
    rdc(`OFS_IRQ_MASK, 33'h3);
    wr(`OFS_MUL_CTRL, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    check({32'h0, irq}, 33'h1);
    rdc(`OFS_IRQ_STATUS, 33'h2);
    rdc(`OFS_MUL_CTRL, 33'h0);
    repeat (3) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    foreach (cfgs[i])
    begin
      bring_up(cfgs[i]);
      n = (cfgs[i][4:3] == SRC_EXT) ? 4 * K : 2 * K;
      if (cfgs[i][2:0] inside {[1:5]})
        n = n * 2 / (cfgs[i][2:0] + 2);
      p0 = pulses;
      u_src.run(K);
      repeat (30) @(posedge pclk);
      check(33'(pulses - p0), 33'(n));
    end
    // reset write in mid-burst: no pulse may come from three cycles after it on
    bring_up(5'h00);
    fork
      u_src.run(40);
      begin
        repeat (300) @(posedge pclk);
        wr(`OFS_MUL_CTRL, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        p0 = pulses;
      end
    join
    check(33'(pulses - p0), 33'h0_0000_0000);
    close_out;
  end
  initial
  begin
    #(25 * 60000);
    failures++;
    close_out;
  end
endmodule
